// ---- hdl/tbu_pkg.sv ----
// Constants shared by the time-base unit: register map, field positions and reset values.
package tbu_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OFF_COUNT_CONTROL   = 6'h00;
  localparam logic [5:0] OFF_TRIGGER_CONTROL = 6'h04;
  localparam logic [5:0] OFF_IRQ_ENABLE      = 6'h0C;
  localparam logic [5:0] OFF_STATUS          = 6'h10;
  localparam logic [5:0] OFF_EVENT_GEN       = 6'h14;
  localparam logic [5:0] OFF_COUNTER         = 6'h24;
  localparam logic [5:0] OFF_PRESCALER       = 6'h28;
  localparam logic [5:0] OFF_PERIOD          = 6'h2C;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_COUNTER_RUN       = 0;
  localparam int BIT_UPDATE_INHIBIT    = 1;
  localparam int BIT_UPDATE_SOURCE     = 2;
  localparam int BIT_SINGLE_SHOT       = 3;
  localparam int BIT_PERIOD_BUFFER     = 7;
  localparam int BIT_FLAG_COPY_ENABLE  = 11;
  localparam int BIT_TRIG_SEL_LSB      = 4;
  localparam int BIT_UPDATE_IRQ_EN     = 0;
  localparam int BIT_UPDATE_DMA_EN     = 8;
  localparam int BIT_UPDATE_FLAG       = 0;
  localparam int BIT_SOFT_UPDATE       = 0;
  localparam int BIT_FLAG_COPY         = 31;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_CONTROL   = 16'h0000;
  localparam logic [15:0] RST_PRESCALER = 16'h0000;
  localparam logic [15:0] RST_PERIOD    = 16'hFFFF;
  localparam logic [15:0] RST_COUNTER   = 16'h0000;

  // ---------------------------------------------------------------------------
  // Trigger source codes and access sizes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] TRIG_SOFT_UPDATE = 3'h0;
  localparam logic [2:0] TRIG_ENABLE      = 3'h1;
  localparam logic [2:0] TRIG_UPDATE      = 3'h2;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage : tbu_pkg

// ---- hdl/tbu_prescaler.sv ----
// Buffered 16-bit prescaler that turns the internal clock into counter ticks.
`timescale 1ns/1ps
`default_nettype none
module tbu_prescaler
  import tbu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Control
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic        load,
  input  wire logic [15:0] psc_preload,
  // Tick out
  output logic             counter_tick
);

  logic [15:0] psc_active;
  logic [15:0] psc_count;
  logic [15:0] next_psc_active;
  logic [15:0] next_psc_count;

  // A tick falls every (active ratio + 1) enabled cycles.
  assign counter_tick = run && (psc_count == psc_active);

  always_comb begin
    next_psc_active = psc_active;
    next_psc_count  = psc_count;
    if (load) begin
      next_psc_active = psc_preload;
    end
    if (clear) begin
      next_psc_count = 16'h0000;
    end else if (counter_tick) begin
      next_psc_count = 16'h0000;
    end else if (run) begin
      next_psc_count = psc_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      psc_active <= RST_PRESCALER;
      psc_count  <= RST_PRESCALER;
    end else begin
      psc_active <= next_psc_active;
      psc_count  <= next_psc_count;
    end
  end

endmodule : tbu_prescaler
`default_nettype wire

// ---- hdl/tbu_period.sv ----
// Active period register fed from the period preload, copied always or on update.
`timescale 1ns/1ps
`default_nettype none
module tbu_period
  import tbu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Control
  input  wire logic        period_buffer_enable,
  input  wire logic        load,
  input  wire logic [15:0] period_preload,
  // Active value
  output logic      [15:0] period_active
);

  logic [15:0] next_period_active;

  always_comb begin
    next_period_active = period_active;
    if (!period_buffer_enable || load) begin
      next_period_active = period_preload;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      period_active <= RST_PERIOD;
    end else begin
      period_active <= next_period_active;
    end
  end

endmodule : tbu_period
`default_nettype wire

// ---- hdl/tbu_timebase.sv ----
// Basic time-base unit: control registers, upcounter, update logic and trigger output.
//
// How it works
// - 16-bit counter counts zero to period, wraps.
// - Prescaler divides clock by value plus one.
// - Prescaler writes take effect at next update.
// - Period preload copied always or at update.
// - Internal enable follows run bit one cycle later.
// - Overflow updates only when not inhibited; reloads.
// - Soft update clears counter and prescaler always.
// - Inhibit blocks update and keeps active prescaler and buffered period.
// - Source select one: only overflow sets flag.
// - Source select zero: any update sets flag.
// - Flag copy appears in counter bit 31.
// - Single shot clears run bit at update.
// - Soft update self-clears; run bit set only by software.
// - Trigger output chosen by trigger source field.
// - Debug halt may freeze counting when selected.
// - Only half-word and word accesses accepted.
// - Counter, period, prescaler accessible while running.
// - Instance holds all its own state.
// - Counter holds while active period is zero.
// - Flag set by hardware, cleared by writing zero.
// - DMA and interrupt requests gated by enables.
`timescale 1ns/1ps
`default_nettype none
module tbu_timebase
  import tbu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [1:0]  reg_size,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_err,
  // Debug
  input  wire logic        dbg_halt,
  input  wire logic        debug_freeze_select,
  // Events
  output logic             trigger_output,
  output logic             update_irq,
  output logic             update_dma_req
);

  // ---------------------------------------------------------------------------
  // Access decoding
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic size_ok(input logic [1:0] size);
    size_ok = (size == SIZE_HALF) || (size == SIZE_WORD);
  endfunction : size_ok

  logic wr_ok;
  logic rd_ok;

  assign wr_ok = reg_wr && size_ok(reg_size);
  assign rd_ok = reg_rd && size_ok(reg_size);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic        counter_run_bit;
  logic        update_inhibit;
  logic        update_source_select;
  logic        single_shot_mode;
  logic        period_buffer_enable;
  logic        flag_copy_enable;
  logic [2:0]  trigger_source_select;
  logic        update_irq_enable;
  logic        update_dma_enable;
  logic        update_flag;
  logic        soft_update_request;
  logic [15:0] prescaler_register;
  logic [15:0] period_register;
  logic [15:0] counter_register;
  logic        counter_enable_internal;

  logic        next_counter_run_bit;
  logic        next_update_inhibit;
  logic        next_update_source_select;
  logic        next_single_shot_mode;
  logic        next_period_buffer_enable;
  logic        next_flag_copy_enable;
  logic [2:0]  next_trigger_source_select;
  logic        next_update_irq_enable;
  logic        next_update_dma_enable;
  logic        next_update_flag;
  logic        next_soft_update_request;
  logic [15:0] next_prescaler_register;
  logic [15:0] next_period_register;
  logic [15:0] next_counter_register;
  logic        next_counter_enable_internal;

  // ---------------------------------------------------------------------------
  // Time-base datapath
  // ---------------------------------------------------------------------------
  logic        run;
  logic        counter_tick;
  logic [15:0] period_active;
  logic        overflow;
  logic        update_event;
  logic        flag_set;

  // Debug halt with debug_freeze_select set only stops the prescaler; registers stay accessible.
  assign run = counter_enable_internal && !(dbg_halt && debug_freeze_select);

  // A zero period blocks the counter so no overflow is ever seen.
  assign overflow = counter_tick && (period_active != 16'h0000)
                    && (counter_register == period_active);

  // Inhibit suppresses the event itself, so neither the prescaler nor a buffered period reloads; an unbuffered period still copies every cycle.
  assign update_event = (overflow || soft_update_request) && !update_inhibit;

  assign flag_set = !update_inhibit
                    && (overflow || (soft_update_request && !update_source_select));

  tbu_prescaler u_prescaler (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .run          (run && counter_run_bit),
    .clear        (soft_update_request),
    .load         (update_event),
    .psc_preload  (prescaler_register),
    .counter_tick (counter_tick)
  );

  tbu_period u_period (
    .clk_sys              (clk_sys),
    .nrst                 (nrst),
    .period_buffer_enable (period_buffer_enable),
    .load                 (update_event),
    .period_preload       (period_register),
    .period_active        (period_active)
  );

  // ---------------------------------------------------------------------------
  // Control and preload registers
  // ---------------------------------------------------------------------------
  always_comb begin
    next_counter_run_bit       = counter_run_bit;
    next_update_inhibit        = update_inhibit;
    next_update_source_select  = update_source_select;
    next_single_shot_mode      = single_shot_mode;
    next_period_buffer_enable  = period_buffer_enable;
    next_flag_copy_enable      = flag_copy_enable;
    next_trigger_source_select = trigger_source_select;
    next_update_irq_enable     = update_irq_enable;
    next_update_dma_enable     = update_dma_enable;
    next_prescaler_register    = prescaler_register;
    next_period_register       = period_register;
    next_soft_update_request   = 1'b0;
    // One-pulse completion is the only hardware path that touches the run bit.
    if (update_event && single_shot_mode) begin
      next_counter_run_bit = 1'b0;
    end
    if (wr_ok && hit(reg_addr, OFF_COUNT_CONTROL)) begin
      next_counter_run_bit      = reg_wdata[BIT_COUNTER_RUN];
      next_update_inhibit       = reg_wdata[BIT_UPDATE_INHIBIT];
      next_update_source_select = reg_wdata[BIT_UPDATE_SOURCE];
      next_single_shot_mode     = reg_wdata[BIT_SINGLE_SHOT];
      next_period_buffer_enable = reg_wdata[BIT_PERIOD_BUFFER];
      next_flag_copy_enable     = reg_wdata[BIT_FLAG_COPY_ENABLE];
    end
    if (wr_ok && hit(reg_addr, OFF_TRIGGER_CONTROL)) begin
      next_trigger_source_select = reg_wdata[BIT_TRIG_SEL_LSB +: 3];
    end
    if (wr_ok && hit(reg_addr, OFF_IRQ_ENABLE)) begin
      next_update_irq_enable = reg_wdata[BIT_UPDATE_IRQ_EN];
      next_update_dma_enable = reg_wdata[BIT_UPDATE_DMA_EN];
    end
    if (wr_ok && hit(reg_addr, OFF_EVENT_GEN)) begin
      next_soft_update_request = reg_wdata[BIT_SOFT_UPDATE];
    end
    if (wr_ok && hit(reg_addr, OFF_PRESCALER)) begin
      next_prescaler_register = reg_wdata[15:0];
    end
    if (wr_ok && hit(reg_addr, OFF_PERIOD)) begin
      next_period_register = reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      counter_run_bit       <= 1'b0;
      update_inhibit        <= 1'b0;
      update_source_select  <= 1'b0;
      single_shot_mode      <= 1'b0;
      period_buffer_enable  <= 1'b0;
      flag_copy_enable      <= 1'b0;
      trigger_source_select <= 3'h0;
      update_irq_enable     <= 1'b0;
      update_dma_enable     <= 1'b0;
      soft_update_request   <= 1'b0;
      prescaler_register    <= RST_PRESCALER;
      period_register       <= RST_PERIOD;
    end else begin
      counter_run_bit       <= next_counter_run_bit;
      update_inhibit        <= next_update_inhibit;
      update_source_select  <= next_update_source_select;
      single_shot_mode      <= next_single_shot_mode;
      period_buffer_enable  <= next_period_buffer_enable;
      flag_copy_enable      <= next_flag_copy_enable;
      trigger_source_select <= next_trigger_source_select;
      update_irq_enable     <= next_update_irq_enable;
      update_dma_enable     <= next_update_dma_enable;
      soft_update_request   <= next_soft_update_request;
      prescaler_register    <= next_prescaler_register;
      period_register       <= next_period_register;
    end
  end

  // ---------------------------------------------------------------------------
  // Counter, internal enable and update flag
  // ---------------------------------------------------------------------------
  always_comb begin
    next_counter_enable_internal = counter_run_bit;
    next_counter_register        = counter_register;
    next_update_flag             = update_flag;
    // Soft update outranks a software write, which outranks counting.
    if (soft_update_request) begin
      next_counter_register = 16'h0000;
    end else if (wr_ok && hit(reg_addr, OFF_COUNTER)) begin
      next_counter_register = reg_wdata[15:0];
    end else if (overflow) begin
      next_counter_register = 16'h0000;
    end else if (counter_tick && (period_active != 16'h0000)) begin
      next_counter_register = counter_register + 16'h0001;
    end
    if (wr_ok && hit(reg_addr, OFF_STATUS) && !reg_wdata[BIT_UPDATE_FLAG]) begin
      next_update_flag = 1'b0;
    end
    // A new event in the clearing cycle is kept.
    if (flag_set) begin
      next_update_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      counter_enable_internal <= 1'b0;
      counter_register        <= RST_COUNTER;
      update_flag             <= 1'b0;
    end else begin
      counter_enable_internal <= next_counter_enable_internal;
      counter_register        <= next_counter_register;
      update_flag             <= next_update_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs: trigger, requests and read data
  // ---------------------------------------------------------------------------
  logic        next_trigger_output;
  logic        next_update_irq;
  logic        next_update_dma_req;
  logic [31:0] next_reg_rdata;
  logic        next_reg_err;

  always_comb begin
    case (trigger_source_select)
      TRIG_SOFT_UPDATE: next_trigger_output = soft_update_request;
      TRIG_ENABLE:      next_trigger_output = counter_enable_internal;
      TRIG_UPDATE:      next_trigger_output = update_event;
      default:          next_trigger_output = 1'b0;
    endcase
    next_update_irq     = next_update_flag && update_irq_enable;
    next_update_dma_req = flag_set && update_dma_enable;
    next_reg_err        = (reg_wr || reg_rd) && !size_ok(reg_size);
    next_reg_rdata      = 32'h0000_0000;
    if (rd_ok) begin
      case (reg_addr)
        OFF_COUNT_CONTROL: begin
          next_reg_rdata[BIT_COUNTER_RUN]      = counter_run_bit;
          next_reg_rdata[BIT_UPDATE_INHIBIT]   = update_inhibit;
          next_reg_rdata[BIT_UPDATE_SOURCE]    = update_source_select;
          next_reg_rdata[BIT_SINGLE_SHOT]      = single_shot_mode;
          next_reg_rdata[BIT_PERIOD_BUFFER]    = period_buffer_enable;
          next_reg_rdata[BIT_FLAG_COPY_ENABLE] = flag_copy_enable;
        end
        OFF_TRIGGER_CONTROL: begin
          next_reg_rdata[BIT_TRIG_SEL_LSB +: 3] = trigger_source_select;
        end
        OFF_IRQ_ENABLE: begin
          next_reg_rdata[BIT_UPDATE_IRQ_EN] = update_irq_enable;
          next_reg_rdata[BIT_UPDATE_DMA_EN] = update_dma_enable;
        end
        OFF_STATUS: begin
          next_reg_rdata[BIT_UPDATE_FLAG] = update_flag;
        end
        OFF_COUNTER: begin
          next_reg_rdata[15:0]          = counter_register;
          next_reg_rdata[BIT_FLAG_COPY] = flag_copy_enable && update_flag;
        end
        OFF_PRESCALER: begin
          next_reg_rdata[15:0] = prescaler_register;
        end
        OFF_PERIOD: begin
          next_reg_rdata[15:0] = period_register;
        end
        default: begin
          next_reg_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trigger_output <= 1'b0;
      update_irq     <= 1'b0;
      update_dma_req <= 1'b0;
      reg_rdata      <= 32'h0000_0000;
      reg_err        <= 1'b0;
    end else begin
      trigger_output <= next_trigger_output;
      update_irq     <= next_update_irq;
      update_dma_req <= next_update_dma_req;
      reg_rdata      <= next_reg_rdata;
      reg_err        <= next_reg_err;
    end
  end

endmodule : tbu_timebase
`default_nettype wire

// ---- testbench/tbu_timebase_properties.sv ----
// Port-level assertions of the time-base unit.
`timescale 1ns/1ps
`default_nettype none
module tbu_timebase_properties
  import tbu_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [1:0]  reg_size,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_err,
  // Debug and events
  input wire logic        dbg_halt,
  input wire logic        debug_freeze_select,
  input wire logic        trigger_output,
  input wire logic        update_irq,
  input wire logic        update_dma_req
);
  // ---------------------------------------------------------------
  // Shadow of the trigger source and of the request enables.
  // ---------------------------------------------------------------
  logic       ok;
  logic       wt;
  logic       ws;
  logic [2:0] sel;
  logic [1:0] en;
  assign ok = reg_size == SIZE_HALF || reg_size == SIZE_WORD;
  assign wt = reg_wr && ok && reg_addr == OFF_TRIGGER_CONTROL;
  assign ws = reg_wr && ok && reg_addr == OFF_EVENT_GEN && reg_wdata[0];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sel <= 3'h0;
      en  <= 2'h0;
    end else begin
      if (wt) begin
        sel <= reg_wdata[6:4];
      end
      if (reg_wr && ok && reg_addr == OFF_IRQ_ENABLE) begin
        en <= {reg_wdata[8], reg_wdata[0]};
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_err_bad_size: assert property ((reg_wr || reg_rd) && !ok |=> reg_err)
    else $error("refused size gave no error");
  a_err_good_size: assert property ((reg_wr || reg_rd) && ok |=> !reg_err)
    else $error("legal size gave an error");
  a_rdata_idle: assert property (!(reg_rd && ok) |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  a_flag_read: assert property (
    reg_rd && ok && reg_addr == OFF_STATUS && update_irq |=> reg_rdata[0])
    else $error("status read lost the flag");
  a_soft_trigger: assert property (ws && sel == TRIG_SOFT_UPDATE |=> ##1 trigger_output)
    else $error("soft update gave no trigger");
  a_trig_off: assert property (sel > TRIG_UPDATE && !wt |=> !trigger_output)
    else $error("unused source drove the trigger");
  a_dma_gate: assert property (!en[1] && !$past(en[1]) |-> !update_dma_req)
    else $error("dma request while disabled");
  a_irq_gate: assert property (!en[0] && !$past(en[0]) |-> !update_irq)
    else $error("interrupt while disabled");
  a_irq_hold: assert property (update_irq && !reg_wr && !$past(reg_wr) |=> update_irq)
    else $error("flag fell without a write");
endmodule : tbu_timebase_properties
`default_nettype wire

// ---- testbench/tbu_timebase_test.sv ----
// Self-checking testbench of the time-base unit.
`timescale 1ns/1ps
`default_nettype none
module tbu_timebase_test import tbu_pkg::*;;
  // ---------------------------------------------------------------
  // Stimulus, tasks and tests.
  // ---------------------------------------------------------------
  logic        clk_sys, nrst, reg_wr, reg_rd, reg_err;
  logic        dbg_halt, debug_freeze_select;
  logic        trigger_output, update_irq, update_dma_req;
  logic [5:0]  reg_addr;
  logic [1:0]  reg_size;
  logic [31:0] reg_wdata, reg_rdata;
  int          miscompares, checked, dmas, n;
  tbu_timebase dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (update_dma_req === 1'b1) dmas++;
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] v,
                     input logic [1:0] s);
    @(posedge clk_sys);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= v;
    reg_size  <= s;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    acc(1'b1, a, v, SIZE_HALF);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string m);
    acc(1'b0, a, 32'h0, SIZE_WORD);
    chk(reg_rdata, e, m);
  endtask : rd
  // Counts cycles up to the next trigger pulse.
  task automatic pulse(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (trigger_output !== 1'b1 && c < 600);
  endtask : pulse
  task automatic quiet(input int k, input string m);
    int p;
    p = 0;
    repeat (k) begin
      @(posedge clk_sys);
      #1;
      if (trigger_output !== 1'b0) p++;
    end
    chk(p, 0, m);
  endtask : quiet
  initial begin
    #3000000;
    miscompares++;
    $display("mismatch at %0t: watchdog", $time);
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_size = SIZE_WORD;
    reg_wdata = 32'h0;
    dbg_halt = 1'b0;
    debug_freeze_select = 1'b0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(OFF_COUNT_CONTROL, {16'h0, RST_CONTROL}, "control reset");
    rd(OFF_TRIGGER_CONTROL, 32'h0, "trigger reset");
    rd(OFF_PERIOD, {16'h0, RST_PERIOD}, "period reset");
    rd(OFF_PRESCALER, {16'h0, RST_PRESCALER}, "prescaler reset");
    wr(6'h08, 32'hFFFF);
    rd(6'h08, 32'h0, "unmapped");
    for (int s = 0; s < 4; s += 3) begin
      acc(1'b1, OFF_COUNT_CONTROL, 32'h1, s[1:0]);
      chk(reg_err, 1'b1, "refused write");
    end
    acc(1'b0, OFF_PERIOD, 32'h0, SIZE_BYTE);
    chk(reg_rdata, 32'h0, "refused read");
    rd(OFF_COUNT_CONTROL, 32'h0, "refused write ignored");
    $display("end reset test");
    wr(OFF_TRIGGER_CONTROL, 32'h20);
    wr(OFF_PERIOD, 32'h3);
    wr(OFF_COUNT_CONTROL, 32'h1);
    for (int p = 0; p < 5; p += 2) begin
      wr(OFF_PRESCALER, p);
      wr(OFF_EVENT_GEN, 32'h1);
      pulse(n);
      pulse(n);
      chk(n, (p + 1) * 4, "tick rate");
    end
    pulse(n);
    wr(OFF_PERIOD, 32'h0);
    quiet(40, "counted at period zero");
    wr(OFF_PERIOD, 32'h3);
    pulse(n);
    wr(OFF_PRESCALER, 32'h0);
    pulse(n);
    chk(n + 2, 20, "ratio kept until update");
    pulse(n);
    chk(n, 4, "ratio after update");
    $display("end rate test");
    for (int b = 0; b < 2; b++) begin
      wr(OFF_COUNT_CONTROL, 32'h1 | (b << 7));
      wr(OFF_PERIOD, 32'h7);
      repeat (3) pulse(n);
      wr(OFF_PERIOD, 32'h3);
      pulse(n);
      chk(n + 2, b ? 8 : 4, "period copy timing");
      pulse(n);
      chk(n, 4, "new period");
    end
    wr(OFF_COUNT_CONTROL, 32'h3);
    quiet(30, "update while inhibited");
    wr(OFF_COUNT_CONTROL, 32'h2);
    acc(1'b1, OFF_COUNTER, 32'hABCD1234, SIZE_WORD);
    rd(OFF_COUNTER, 32'h1234, "counter write");
    wr(OFF_EVENT_GEN, 32'h1);
    rd(OFF_COUNTER, 32'h0, "soft update clear");
    rd(OFF_EVENT_GEN, 32'h0, "request clears");
    $display("end buffer test");
    wr(OFF_IRQ_ENABLE, 32'h101);
    for (int s = 1; s >= 0; s--) begin
      wr(OFF_COUNT_CONTROL, 32'h800 | (s << 2));
      wr(OFF_STATUS, 32'h0);
      n = dmas;
      wr(OFF_EVENT_GEN, 32'h1);
      rd(OFF_STATUS, !s, "flag by source");
      chk(update_irq, !s, "irq level");
      chk(dmas - n, !s, "dma pulses");
      rd(OFF_COUNTER, s ? 0 : 32'h80000000, "flag copy");
    end
    wr(OFF_COUNT_CONTROL, 32'h0);
    rd(OFF_COUNTER, 32'h0, "copy off");
    wr(OFF_STATUS, 32'h1);
    rd(OFF_STATUS, 32'h1, "write one keeps flag");
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h0, "write zero clears");
    wr(OFF_COUNT_CONTROL, 32'h5);
    pulse(n);
    rd(OFF_STATUS, 32'h1, "overflow flag");
    $display("end flag test");
    wr(OFF_COUNT_CONTROL, 32'h9);
    pulse(n);
    rd(OFF_COUNT_CONTROL, 32'h8, "single shot stop");
    quiet(20, "count after single shot");
    wr(OFF_TRIGGER_CONTROL, 32'h0);
    wr(OFF_EVENT_GEN, 32'h1);
    chk(trigger_output, 1'b0, "early soft trigger");
    @(posedge clk_sys);
    #1;
    chk(trigger_output, 1'b1, "soft trigger");
    wr(OFF_TRIGGER_CONTROL, 32'h30);
    wr(OFF_EVENT_GEN, 32'h1);
    quiet(5, "unused trigger code");
    wr(OFF_TRIGGER_CONTROL, 32'h10);
    wr(OFF_COUNT_CONTROL, 32'h1);
    quiet(1, "enable too early");
    @(posedge clk_sys);
    #1;
    chk(trigger_output, 1'b1, "enable trigger");
    $display("end trigger test");
    wr(OFF_TRIGGER_CONTROL, 32'h20);
    @(posedge clk_sys);
    dbg_halt <= 1'b1;
    debug_freeze_select <= 1'b1;
    quiet(30, "counted while frozen");
    @(posedge clk_sys);
    debug_freeze_select <= 1'b0;
    pulse(n);
    chk(n < 5, 1'b1, "halt without freeze");
    dbg_halt <= 1'b0;
    $display("end debug test");
    give_verdict();
  end
endmodule : tbu_timebase_test
bind tbu_timebase tbu_timebase_properties u_props (.*);
`default_nettype wire
